// ==== shared/vf_shadow_defs.vh ====
`ifndef VF_SHADOW_DEFS_VH
`define VF_SHADOW_DEFS_VH

// =====================================================================
// widths and table depth
`define PF_W 1
`define VF_W 11
`define CNT_W 12
`define CFG_W 7
`define IDX_W 13
`define DEPTH 8192

// =====================================================================
// source bits inside the configuration registers
`define CMD_BME_BIT 2
`define MSIX_MASK_BIT 14
`define MSIX_EN_BIT 15
`define TPH_ST_LO_BIT 0
`define TPH_ST_HI_BIT 1
`define TPH_EN_BIT 8
`define ATS_EN_BIT 15

// =====================================================================
// positions in the field-value vector
`define FLD_BME 0
`define FLD_MSIX_MASK 1
`define FLD_MSIX_EN 2
`define FLD_TPH_ST_LO 3
`define FLD_TPH_ST_HI 4
`define FLD_TPH_EN 5
`define FLD_ATS_EN 6

// =====================================================================
// written-register select codes
`define SEL_CMD 2'h0
`define SEL_MSIX 2'h1
`define SEL_TPH 2'h2
`define SEL_ATS 2'h3

// =====================================================================
// software register offsets and reset values
`define OFS_NUM_PF 8'h00
`define OFS_NUM_VF0 8'h04
`define OFS_NUM_VF1 8'h08
`define OFS_STATUS 8'h0c
`define OFS_RECORDS 8'h10
`define RST_NUM_PF 2'h1
`define RST_NUM_VF 12'h000

`endif

// ==== rtl/shadow_store.v ====
`timescale 1ns/1ps
`include "vf_shadow_defs.vh"

// =====================================================================
// per-function field table, one write port, registered read port
module shadow_store (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_n_i,
  // write port
  input wire wr_en_i,
  input wire [`IDX_W-1:0] wr_addr_i,
  input wire [`CFG_W-1:0] wr_data_i,
  // read port
  input wire rd_en_i,
  input wire [`IDX_W-1:0] rd_addr_i,
  output reg [`CFG_W-1:0] rd_data_o
);

  reg [`CFG_W-1:0] mem [0:`DEPTH-1];

  // array holds no reset; the owner clears it by a sweep
  always @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // read data one cycle after the read enable
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= {`CFG_W{1'b0}};
    end else if (rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule // shadow_store

// ==== rtl/vf_control_shadow_monitor.v ====
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "vf_shadow_defs.vh"

// =====================================================================
// control shadow monitor: mirrors function control fields to the app
module vf_control_shadow_monitor (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_n_i,
  // completed configuration writes from the root port side
  input wire cfg_wr_i,
  input wire [`PF_W-1:0] cfg_wr_pf_i,
  input wire cfg_wr_vf_active_i,
  input wire [`VF_W-1:0] cfg_wr_vf_i,
  input wire [1:0] cfg_wr_sel_i,
  input wire [15:0] cfg_wr_data_i,
  input wire [1:0] cfg_wr_be_i,
  output reg cfg_wr_ready_o,
  // shadow record to the application
  input wire shadow_req_all_i,
  output reg shadow_update_o,
  output reg [`CFG_W-1:0] shadow_cfg_o,
  output reg [`PF_W-1:0] shadow_parent_func_num_o,
  output reg shadow_virtual_func_flag_o,
  output reg [`VF_W-1:0] shadow_virtual_func_offset_o,
  // software register port
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o
);

  // one-hot states
  localparam [5:0] ST_INIT = 6'h01;
  localparam [5:0] ST_IDLE = 6'h02;
  localparam [5:0] ST_WRD = 6'h04;
  localparam [5:0] ST_WMG = 6'h08;
  localparam [5:0] ST_SRD = 6'h10;
  localparam [5:0] ST_SEM = 6'h20;
  reg [5:0] state_q;
  reg [5:0] state_d;

  // =====================================================================
  // software registers
  reg [1:0] num_pf_q;
  wire [`CNT_W-1:0] num_vf [0:1];
  reg [15:0] records_q;
  reg scan_on_q;
  reg [`IDX_W-1:0] init_ptr_q;

  // attached virtual-function counts, one register per parent
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_numvf
      reg [`CNT_W-1:0] num_vf_q;
      wire [7:0] ofs = (g == 0) ? `OFS_NUM_VF0 : `OFS_NUM_VF1;
      always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          num_vf_q <= `RST_NUM_VF;
        end else if (reg_wr_i && reg_addr_i == ofs) begin
          num_vf_q <= reg_wdata_i[`CNT_W-1:0];
        end
      end
      assign num_vf[g] = num_vf_q;
    end
  endgenerate

  // parent count, 1 or 2; other values keep the old setting
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      num_pf_q <= `RST_NUM_PF;
    end else if (reg_wr_i && reg_addr_i == `OFS_NUM_PF) begin
      if (reg_wdata_i[1:0] == 2'h1 || reg_wdata_i[1:0] == 2'h2) begin
        num_pf_q <= reg_wdata_i[1:0];
      end
    end
  end

  // record counter: a pulse in the clearing cycle still counts
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      records_q <= 16'h0000;
    end else if (reg_wr_i && reg_addr_i == `OFS_RECORDS) begin
      records_q <= {15'h0000, shadow_update_o};
    end else if (shadow_update_o) begin
      records_q <= records_q + 16'h0001;
    end
  end

  // read data stand one cycle after the read strobe; unmapped reads zero
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `OFS_NUM_PF: reg_rdata_o <= {30'h00000000, num_pf_q};
        `OFS_NUM_VF0: reg_rdata_o <= {20'h00000, num_vf[0]};
        `OFS_NUM_VF1: reg_rdata_o <= {20'h00000, num_vf[1]};
        `OFS_STATUS: reg_rdata_o <= {29'h00000000, ~cfg_wr_ready_o,
                                     scan_on_q, state_q[0]};
        `OFS_RECORDS: reg_rdata_o <= {16'h0000, records_q};
        default: reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

  // =====================================================================
  // pending configuration write
  reg pend_q;
  reg [`PF_W-1:0] pend_pf_q;
  reg pend_vfa_q;
  reg [`VF_W-1:0] pend_vf_q;
  reg [1:0] pend_sel_q;
  reg [15:0] pend_data_q;
  reg [1:0] pend_be_q;
  // only one write is held; the writer waits on ready
  wire take_wr = cfg_wr_i & cfg_wr_ready_o;
  wire pend_done = state_q[3];
  wire pend_d = take_wr | (pend_q & ~pend_done);

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_q <= 1'b0;
      pend_pf_q <= {`PF_W{1'b0}};
      pend_vfa_q <= 1'b0;
      pend_vf_q <= {`VF_W{1'b0}};
      pend_sel_q <= `SEL_CMD;
      pend_data_q <= 16'h0000;
      pend_be_q <= 2'h0;
    end else begin
      pend_q <= pend_d;
      if (take_wr) begin
        pend_pf_q <= cfg_wr_pf_i;
        pend_vfa_q <= cfg_wr_vf_active_i;
        pend_vf_q <= cfg_wr_vf_active_i ? cfg_wr_vf_i : {`VF_W{1'b0}};
        pend_sel_q <= cfg_wr_sel_i;
        pend_data_q <= cfg_wr_data_i;
        pend_be_q <= cfg_wr_be_i;
      end
    end
  end

  // ready from a flop, low during the clearing sweep
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_wr_ready_o <= 1'b0;
    end else begin
      cfg_wr_ready_o <= ~pend_d & ~state_d[0];
    end
  end

  // =====================================================================
  // merge of written data into the stored vector
  wire [`CFG_W-1:0] old_cfg;
  reg [`CFG_W-1:0] new_cfg;
  reg touched;

  always @* begin
    new_cfg = old_cfg;
    touched = 1'b0;
    case (pend_sel_q)
      `SEL_CMD: begin
        if (pend_be_q[0]) begin
          new_cfg[`FLD_BME] = pend_data_q[`CMD_BME_BIT];
          touched = 1'b1;
        end
      end
      `SEL_MSIX: begin
        if (pend_be_q[1]) begin
          new_cfg[`FLD_MSIX_MASK] = pend_data_q[`MSIX_MASK_BIT];
          new_cfg[`FLD_MSIX_EN] = pend_data_q[`MSIX_EN_BIT];
          touched = 1'b1;
        end
      end
      `SEL_TPH: begin
        if (pend_be_q[0]) begin
          new_cfg[`FLD_TPH_ST_LO] = pend_data_q[`TPH_ST_LO_BIT];
          new_cfg[`FLD_TPH_ST_HI] = pend_data_q[`TPH_ST_HI_BIT];
          touched = 1'b1;
        end
        if (pend_be_q[1]) begin
          new_cfg[`FLD_TPH_EN] = pend_data_q[`TPH_EN_BIT];
          touched = 1'b1;
        end
      end
      `SEL_ATS: begin
        if (pend_be_q[1]) begin
          new_cfg[`FLD_ATS_EN] = pend_data_q[`ATS_EN_BIT];
          touched = 1'b1;
        end
      end
      default: new_cfg = old_cfg;
    endcase
  end

  // =====================================================================
  // scan pointer and its successor
  reg [`PF_W-1:0] scan_pf_q;
  reg scan_vfa_q;
  reg [`VF_W-1:0] scan_vf_q;
  reg [`PF_W-1:0] nxt_pf;
  reg nxt_vfa;
  reg [`VF_W-1:0] nxt_vf;
  reg scan_last;
  wire [`CNT_W-1:0] cur_cnt = num_vf[scan_pf_q];
  wire [`CNT_W-1:0] vf_plus = {1'b0, scan_vf_q} + 12'h001;

  // order: parent, its virtual functions, then the next parent
  always @* begin
    nxt_pf = scan_pf_q;
    nxt_vfa = 1'b0;
    nxt_vf = {`VF_W{1'b0}};
    scan_last = 1'b0;
    if (!scan_vfa_q && cur_cnt != 12'h000) begin
      nxt_vfa = 1'b1;
    end else if (scan_vfa_q && vf_plus < cur_cnt) begin
      nxt_vfa = 1'b1;
      nxt_vf = vf_plus[`VF_W-1:0];
    end else if (scan_pf_q == 1'b0 && num_pf_q == 2'h2) begin
      nxt_pf = 1'b1;
    end else begin
      nxt_pf = 1'b0;
      scan_last = 1'b1;
    end
  end

  // =====================================================================
  // sequencer
  wire scan_start = shadow_req_all_i;
  wire sem_last = state_q[5] & scan_last;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_INIT: begin
        if (init_ptr_q == `DEPTH - 1) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (pend_q) begin
          state_d = ST_WRD;
        end else if (scan_start) begin
          state_d = ST_SRD;
        end
      end
      ST_WRD: state_d = ST_WMG;
      ST_WMG: state_d = scan_on_q ? ST_SRD : ST_IDLE;
      ST_SRD: state_d = pend_q ? ST_WRD : ST_SEM;
      ST_SEM: begin
        if (pend_q) begin
          state_d = ST_WRD;
        end else if (scan_last && !shadow_req_all_i) begin
          state_d = ST_IDLE;
        end else begin
          state_d = ST_SRD;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // clearing sweep so every function starts with all fields zero
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      init_ptr_q <= {`IDX_W{1'b0}};
    end else if (state_q[0]) begin
      init_ptr_q <= init_ptr_q + 13'h0001;
    end
  end

  // scan flag and pointer; a write during a scan moves the pointer to its function
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scan_on_q <= 1'b0;
      scan_pf_q <= {`PF_W{1'b0}};
      scan_vfa_q <= 1'b0;
      scan_vf_q <= {`VF_W{1'b0}};
    end else if (state_q[1] && !pend_q && scan_start) begin
      scan_on_q <= 1'b1;
      scan_pf_q <= {`PF_W{1'b0}};
      scan_vfa_q <= 1'b0;
      scan_vf_q <= {`VF_W{1'b0}};
    end else if (pend_done && scan_on_q) begin
      scan_pf_q <= pend_pf_q;
      scan_vfa_q <= pend_vfa_q;
      scan_vf_q <= pend_vf_q;
    end else if (state_q[5]) begin
      scan_pf_q <= nxt_pf;
      scan_vfa_q <= nxt_vfa;
      scan_vf_q <= nxt_vf;
      if (sem_last && !pend_q) begin
        scan_on_q <= shadow_req_all_i;
      end
    end
  end

  // =====================================================================
  // table access
  wire mem_we;
  wire [`IDX_W-1:0] mem_waddr;
  wire [`CFG_W-1:0] mem_wdata;
  wire mem_re;
  wire [`IDX_W-1:0] mem_raddr;
  wire [`IDX_W-1:0] pend_idx;
  wire [`IDX_W-1:0] scan_idx;
  assign pend_idx = {pend_pf_q, pend_vfa_q, pend_vf_q};
  assign scan_idx = {scan_pf_q, scan_vfa_q, scan_vf_q};
  assign mem_we = state_q[0] | (pend_done & touched);
  assign mem_waddr = state_q[0] ? init_ptr_q : pend_idx;
  assign mem_wdata = state_q[0] ? {`CFG_W{1'b0}} : new_cfg;
  assign mem_re = state_q[2] | state_q[4];
  assign mem_raddr = state_q[2] ? pend_idx : scan_idx;

  shadow_store u_store (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(mem_we),
    .wr_addr_i(mem_waddr),
    .wr_data_i(mem_wdata),
    .rd_en_i(mem_re),
    .rd_addr_i(mem_raddr),
    .rd_data_o(old_cfg)
  );

  // =====================================================================
  // record outputs: values live only in the pulse cycle
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shadow_update_o <= 1'b0;
      shadow_cfg_o <= {`CFG_W{1'b0}};
      shadow_parent_func_num_o <= {`PF_W{1'b0}};
      shadow_virtual_func_flag_o <= 1'b0;
      shadow_virtual_func_offset_o <= {`VF_W{1'b0}};
    end else if (pend_done && touched) begin
      shadow_update_o <= 1'b1;
      shadow_cfg_o <= new_cfg;
      shadow_parent_func_num_o <= pend_pf_q;
      shadow_virtual_func_flag_o <= pend_vfa_q;
      shadow_virtual_func_offset_o <= pend_vf_q;
    end else if (state_q[5] && !pend_q) begin
      shadow_update_o <= 1'b1;
      shadow_cfg_o <= old_cfg;
      shadow_parent_func_num_o <= scan_pf_q;
      shadow_virtual_func_flag_o <= scan_vfa_q;
      shadow_virtual_func_offset_o <= scan_vf_q;
    end else begin
      // zeroed between pulses; the app keeps its own copy
      shadow_update_o <= 1'b0;
      shadow_cfg_o <= {`CFG_W{1'b0}};
      shadow_parent_func_num_o <= {`PF_W{1'b0}};
      shadow_virtual_func_flag_o <= 1'b0;
      shadow_virtual_func_offset_o <= {`VF_W{1'b0}};
    end
  end

endmodule // vf_control_shadow_monitor

// ==== dv/shadow_monitor_assertions.sv ====
`timescale 1ns/1ps
`include "vf_shadow_defs.vh"

// =====================================================================
// port checker for the shadow monitor
module shadow_monitor_checker (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_n_i,
  // configuration writes
  input wire cfg_wr_i,
  input wire [`PF_W-1:0] cfg_wr_pf_i,
  input wire cfg_wr_vf_active_i,
  input wire [`VF_W-1:0] cfg_wr_vf_i,
  input wire [1:0] cfg_wr_sel_i,
  input wire [15:0] cfg_wr_data_i,
  input wire [1:0] cfg_wr_be_i,
  input wire cfg_wr_ready_o,
  // record
  input wire shadow_update_o,
  input wire [`CFG_W-1:0] shadow_cfg_o,
  input wire [`PF_W-1:0] shadow_parent_func_num_o,
  input wire shadow_virtual_func_flag_o,
  input wire [`VF_W-1:0] shadow_virtual_func_offset_o
);
  wire taken;
  wire touched;
  wire id_ok;
  reg [`PF_W-1:0] pf_q;
  reg vfa_q;
  reg [`VF_W-1:0] vf_q;
  reg [15:0] dat_q;

  // accepted write, and whether a mirrored byte is enabled
  assign taken = cfg_wr_i && cfg_wr_ready_o;
  assign touched = (cfg_wr_sel_i == `SEL_TPH) ? |cfg_wr_be_i :
    (cfg_wr_sel_i == `SEL_CMD) ? cfg_wr_be_i[0] : cfg_wr_be_i[1];
  // a record naming the function of the held write
  assign id_ok = shadow_update_o && shadow_parent_func_num_o == pf_q &&
    shadow_virtual_func_flag_o == vfa_q &&
    shadow_virtual_func_offset_o == (vfa_q ? vf_q : 11'h000);

  // hold the accepted write; low ready keeps a second one out meanwhile
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pf_q <= 1'h0;
      vfa_q <= 1'h0;
      vf_q <= 11'h000;
      dat_q <= 16'h0000;
    end else if (taken) begin
      pf_q <= cfg_wr_pf_i;
      vfa_q <= cfg_wr_vf_active_i;
      vf_q <= cfg_wr_vf_i;
      dat_q <= cfg_wr_data_i;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  // =====================================================================
  // record shape
  one_pulse_a: assert property (
    shadow_update_o |=> !shadow_update_o)
    else $error("update wider than one cycle");
  idle_clear_a: assert property (
    !shadow_update_o |-> shadow_cfg_o == 7'h00 && !shadow_virtual_func_flag_o
    && shadow_parent_func_num_o == 1'h0 && shadow_virtual_func_offset_o == 0)
    else $error("record outputs not cleared outside pulse");
  pf_offset_a: assert property (
    shadow_update_o && !shadow_virtual_func_flag_o |->
    shadow_virtual_func_offset_o == 11'h000)
    else $error("offset nonzero for parent function");

  // =====================================================================
  // write answers; slack covers a scan record in flight
  ready_drop_a: assert property (
    taken |=> !cfg_wr_ready_o)
    else $error("ready still high after accepted write");
  write_ident_a: assert property (
    taken && touched |-> ##[3:10] id_ok)
    else $error("no record for written function");
  bme_mirror_a: assert property (
    taken && cfg_wr_sel_i == `SEL_CMD && cfg_wr_be_i[0] |->
    ##[3:10] (id_ok && shadow_cfg_o[0] == dat_q[2]))
    else $error("bus master bit not mirrored");
  msix_mirror_a: assert property (
    taken && cfg_wr_sel_i == `SEL_MSIX && cfg_wr_be_i[1] |->
    ##[3:10] (id_ok && shadow_cfg_o[2:1] == dat_q[15:14]))
    else $error("message control bits not mirrored");
  ats_mirror_a: assert property (
    taken && cfg_wr_sel_i == `SEL_ATS && cfg_wr_be_i[1] |->
    ##[3:10] (id_ok && shadow_cfg_o[6] == dat_q[15]))
    else $error("translation enable not mirrored");
endmodule // shadow_monitor_checker

bind vf_control_shadow_monitor shadow_monitor_checker i_checker (
  .clk_sys_i, .reset_n_i, .cfg_wr_i, .cfg_wr_pf_i, .cfg_wr_vf_active_i,
  .cfg_wr_vf_i, .cfg_wr_sel_i, .cfg_wr_data_i, .cfg_wr_be_i,
  .cfg_wr_ready_o, .shadow_update_o, .shadow_cfg_o,
  .shadow_parent_func_num_o, .shadow_virtual_func_flag_o,
  .shadow_virtual_func_offset_o
);

// ==== dv/app_shadow_copy.sv ====
`timescale 1ns/1ps

// =====================================================================
// application side: keeps its own copy of the latest record
module app_shadow_copy (
  // clock and reset
  input wire clk_sys_i,
  input wire reset_n_i,
  // record from the monitor
  input wire upd_i,
  input wire [6:0] cfg_i,
  input wire pf_i,
  input wire vfa_i,
  input wire [10:0] vf_i,
  // scan control
  input wire scan_on_i,
  output wire req_all_o,
  // captured copy and record count
  output reg [19:0] rec_o,
  output reg [15:0] seen_o
);
  // level request; held high gives continuous refresh
  assign req_all_o = scan_on_i;
  // copy in the pulse cycle, the outputs are gone a cycle later
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rec_o <= 20'h00000;
      seen_o <= 16'h0000;
    end else if (upd_i) begin
      rec_o <= {cfg_i, pf_i, vfa_i, vf_i};
      seen_o <= seen_o + 16'h0001;
    end
  end
endmodule // app_shadow_copy

// ==== dv/vf_control_shadow_monitor_test.sv ====
`timescale 1ns/1ps
`include "vf_shadow_defs.vh"

`define check_eq(nm, ex, gt) begin checked = checked + 1; \
  if ((gt) !== (ex)) begin n_mismatch = n_mismatch + 1; \
  $display("unexpected %s exp %h got %h", nm, ex, gt); end end

// =====================================================================
// bench for the control shadow monitor
module vf_control_shadow_monitor_test;
  reg clk_sys_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg cfg_wr_i = 1'b0;
  reg [`PF_W-1:0] cfg_wr_pf_i = 1'h0;
  reg cfg_wr_vf_active_i = 1'b0;
  reg [`VF_W-1:0] cfg_wr_vf_i = 11'h000;
  reg [1:0] cfg_wr_sel_i = 2'h0;
  reg [15:0] cfg_wr_data_i = 16'h0000;
  reg [1:0] cfg_wr_be_i = 2'h0;
  reg scan_on = 1'b0;
  reg [7:0] reg_addr_i = 8'h00;
  reg [31:0] reg_wdata_i = 32'h0;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  wire cfg_wr_ready_o;
  wire shadow_req_all_i;
  wire shadow_update_o;
  wire [`CFG_W-1:0] shadow_cfg_o;
  wire [`PF_W-1:0] shadow_parent_func_num_o;
  wire shadow_virtual_func_flag_o;
  wire [`VF_W-1:0] shadow_virtual_func_offset_o;
  wire [31:0] reg_rdata_o;
  wire [19:0] rec;
  wire [15:0] seen;
  reg [15:0] last_seen = 16'h0;
  reg [19:0] got;
  integer n_mismatch = 0;
  integer checked = 0;
  integer k;

  vf_control_shadow_monitor i_dut (.clk_sys_i, .reset_n_i, .cfg_wr_i,
    .cfg_wr_pf_i, .cfg_wr_vf_active_i, .cfg_wr_vf_i, .cfg_wr_sel_i,
    .cfg_wr_data_i, .cfg_wr_be_i, .cfg_wr_ready_o, .shadow_req_all_i,
    .shadow_update_o, .shadow_cfg_o, .shadow_parent_func_num_o,
    .shadow_virtual_func_flag_o, .shadow_virtual_func_offset_o,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
  app_shadow_copy i_app (.clk_sys_i, .reset_n_i, .upd_i(shadow_update_o),
    .cfg_i(shadow_cfg_o), .pf_i(shadow_parent_func_num_o),
    .vfa_i(shadow_virtual_func_flag_o), .vf_i(shadow_virtual_func_offset_o),
    .scan_on_i(scan_on), .req_all_o(shadow_req_all_i), .rec_o(rec),
    .seen_o(seen));

  // 200 MHz
  always #2.5 clk_sys_i = ~clk_sys_i;

  // =====================================================================
  // helpers
  function [19:0] mk(input [6:0] c, input p, input a, input [10:0] v);
    mk = {c, p, a, v};
  endfunction
  // scan order with two parents, three and two virtuals
  function [19:0] scan_exp(input integer i);
    case (i)
      0: scan_exp = mk(7'h00, 1'b0, 1'b0, 11'h000);
      1: scan_exp = mk(7'h00, 1'b0, 1'b1, 11'h000);
      2: scan_exp = mk(7'h00, 1'b0, 1'b1, 11'h001);
      3: scan_exp = mk(7'h7b, 1'b0, 1'b1, 11'h002);
      4: scan_exp = mk(7'h01, 1'b1, 1'b0, 11'h000);
      5: scan_exp = mk(7'h00, 1'b1, 1'b1, 11'h000);
      default: scan_exp = mk(7'h00, 1'b1, 1'b1, 11'h001);
    endcase
  endfunction
  // trailing edge keeps a strobe from being set twice in one step
  task reg_wr(input [7:0] a, input [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task reg_rd(input [7:0] a, input [31:0] ex);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_sys_i);
    `check_eq("reg_rdata_o", ex, reg_rdata_o)
  endtask
  task cfg_write(input p, input a, input [10:0] v, input [1:0] s,
    input [15:0] d, input [1:0] b);
    @(posedge clk_sys_i);
    for (k = 0; k < 40 && cfg_wr_ready_o !== 1'b1; k = k + 1)
      @(posedge clk_sys_i);
    cfg_wr_pf_i <= p;
    cfg_wr_vf_active_i <= a;
    cfg_wr_vf_i <= v;
    cfg_wr_sel_i <= s;
    cfg_wr_data_i <= d;
    cfg_wr_be_i <= b;
    cfg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    cfg_wr_i <= 1'b0;
  endtask
  // next record from the application copy, bounded wait
  task get_rec;
    for (k = 0; k < 60 && seen === last_seen; k = k + 1)
      @(posedge clk_sys_i);
    `check_eq("record arrival", 1'b1, seen !== last_seen)
    last_seen = last_seen + 16'h1;
    got = rec;
  endtask
  task quiet;
    repeat (20) @(posedge clk_sys_i);
    `check_eq("record count", last_seen, seen)
  endtask

  // =====================================================================
  // scenarios
  task t_regs;
    reg_rd(`OFS_NUM_PF, 32'h1);
    reg_rd(`OFS_NUM_VF0, 32'h0);
    reg_rd(8'h40, 32'h0);
    reg_wr(`OFS_NUM_PF, 32'h3);
    reg_rd(`OFS_NUM_PF, 32'h1);
    reg_wr(`OFS_NUM_PF, 32'h2);
    reg_wr(`OFS_NUM_VF0, 32'h3);
    reg_wr(`OFS_NUM_VF1, 32'h2);
    reg_rd(`OFS_NUM_VF1, 32'h2);
  endtask
  // each register of one virtual builds up the vector
  task t_write;
    cfg_write(1'b0, 1'b1, 11'h002, `SEL_CMD, 16'h0004, 2'b01);
    get_rec;
    `check_eq("cmd rec", mk(7'h01, 1'b0, 1'b1, 11'h002), got)
    cfg_write(1'b0, 1'b1, 11'h002, `SEL_MSIX, 16'hc000, 2'b10);
    get_rec;
    `check_eq("msix rec", mk(7'h07, 1'b0, 1'b1, 11'h002), got)
    cfg_write(1'b0, 1'b1, 11'h002, `SEL_TPH, 16'h0103, 2'b11);
    get_rec;
    `check_eq("tph rec", mk(7'h3f, 1'b0, 1'b1, 11'h002), got)
    cfg_write(1'b0, 1'b1, 11'h002, `SEL_ATS, 16'h8000, 2'b10);
    get_rec;
    `check_eq("ats rec", mk(7'h7f, 1'b0, 1'b1, 11'h002), got)
    cfg_write(1'b0, 1'b1, 11'h002, `SEL_CMD, 16'hfffb, 2'b10);
    quiet;
    cfg_write(1'b0, 1'b1, 11'h002, `SEL_MSIX, 16'h4000, 2'b10);
    get_rec;
    `check_eq("mask rec", mk(7'h7b, 1'b0, 1'b1, 11'h002), got)
  endtask
  // parent identity, and the largest virtual offset
  task t_ident;
    cfg_write(1'b1, 1'b0, 11'h7ff, `SEL_CMD, 16'h0004, 2'b01);
    get_rec;
    `check_eq("pf rec", mk(7'h01, 1'b1, 1'b0, 11'h000), got)
    cfg_write(1'b0, 1'b1, 11'h7ff, `SEL_ATS, 16'h8000, 2'b10);
    get_rec;
    `check_eq("top vf rec", mk(7'h40, 1'b0, 1'b1, 11'h7ff), got)
  endtask
  // request dropped after the first record: one scan only
  task t_scan;
    integer i;
    scan_on <= 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      get_rec;
      scan_on <= 1'b0;
      `check_eq("scan rec", scan_exp(i), got)
    end
    quiet;
    // fourteen records so far: five writes, two ident, seven scanned
    reg_rd(`OFS_RECORDS, 32'he);
    reg_wr(`OFS_RECORDS, 32'h0);
    reg_rd(`OFS_RECORDS, 32'h0);
  endtask
  // request still high at the end starts a second full scan
  task t_rescan;
    integer i;
    scan_on <= 1'b1;
    for (i = 0; i < 14; i = i + 1) begin
      get_rec;
      if (i == 8) begin
        scan_on <= 1'b0;
      end
      `check_eq("rescan rec", scan_exp(i % 7), got)
    end
    quiet;
  endtask
  // write in mid-scan is reported, then the scan resumes there
  task t_preempt;
    integer i;
    scan_on <= 1'b1;
    get_rec;
    get_rec;
    scan_on <= 1'b0;
    cfg_write(1'b0, 1'b1, 11'h001, `SEL_CMD, 16'h0004, 2'b01);
    // two scan records leave before the write is reported
    get_rec;
    `check_eq("scan rec", scan_exp(2), got)
    get_rec;
    `check_eq("scan rec", scan_exp(3), got)
    get_rec;
    `check_eq("write rec", mk(7'h01, 1'b0, 1'b1, 11'h001), got)
    get_rec;
    `check_eq("resume rec", mk(7'h01, 1'b0, 1'b1, 11'h001), got)
    for (i = 3; i < 7; i = i + 1) begin
      get_rec;
      `check_eq("tail rec", scan_exp(i), got)
    end
    quiet;
  endtask

  task wrap_up;
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // =====================================================================
  // main sequence; the table sweep takes most of the run
  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_regs;
    for (k = 0; k < 9000 && cfg_wr_ready_o !== 1'b1; k = k + 1)
      @(posedge clk_sys_i);
    `check_eq("ready after sweep", 1'b1, cfg_wr_ready_o)
    t_write;
    t_ident;
    t_scan;
    t_rescan;
    t_preempt;
    wrap_up;
  end

  // watchdog: sweep plus all scenarios stay well inside this span
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end
endmodule // vf_control_shadow_monitor_test
